// [hdl/flsip_defs.vh]
// Constants of the serial flash status, identification and protection block
`ifndef FLSIP_DEFS_VH
`define FLSIP_DEFS_VH
`define FLSIP_OP_WREN 8'h06
`define FLSIP_OP_WRDI 8'h04
`define FLSIP_OP_RDID 8'h9f
`define FLSIP_OP_RDSR 8'h05
`define FLSIP_OP_WRSR 8'h01
`define FLSIP_OP_PP 8'h02
`define FLSIP_OP_SE 8'hd8
`define FLSIP_OP_BE 8'hc7
`define FLSIP_SR_BUSY 0
`define FLSIP_SR_LATCH 1
`define FLSIP_SR_GUARD_LO 2
`define FLSIP_SR_GUARD_HI 4
`define FLSIP_SR_LOCK 7
`define FLSIP_SR_RESET 8'h00
`define FLSIP_GUARD_RESET 3'h0
`define FLSIP_SYNC_RESET 4'he
`define FLSIP_ID_LEN 8'h10
`define FLSIP_ID_BYTES 5'h14
`define FLSIP_ADDR_BYTES 5'h03
`define FLSIP_WRSR_BYTES 5'h01
`define FLSIP_SECT_HI 20
`define FLSIP_SECT_LO 16
`endif

// [hdl/flsip_core.v]
// Serial flash command logic: latch, status, identification and guard protection
//
// Behaviour
// - Write-disable opcode framed by chip select clears the write latch.
// - Latch clears at reset and at end of erase, program, status write, write-disable.
// - Identification: maker byte, type, capacity, then length plus 16 factory bytes.
// - Length byte reads sixteen; factory bytes are read-only, zero by default.
// - Identification opcode is not decoded while an internal cycle runs.
// - After opcode, identity, length and factory bytes shift out on falling clock.
// - Raising chip select ends any readout; device returns to standby.
// - Status read works at any time and repeats the byte while clocked.
// - Busy bit is one during status-write, program or erase cycles.
// - Latch bit mirrors latch; status-write, program, erase refused when clear.
// - Guard bits persist and change only via status write.
// - Program and sector erase into the guarded region are refused.
// - Guard bits writable only outside hardware locked mode.
// - Bulk erase runs only when all guard bits are zero.
// - Hardware locked mode when lock bit is one and protect pin is low.
// - Locked mode makes lock and guard bits read-only; status writes refused.
// - All bits travel most significant bit first.
// - Opcodes: write-disable 04h, identification 9Fh, status read 05h.
// - Write commands need chip select raised on a byte boundary, else discarded.
// - Status bits six and five always read zero.
`timescale 1ns/1ps
`default_nettype none
`include "flsip_defs.vh"
module flsip_core #(
  parameter [7:0] MAKER_ID = 8'h5a,        // Arbitrary value
  parameter [7:0] TYPE_ID = 8'h3c,         // Arbitrary value
  parameter [7:0] CAP_ID = 8'h0e,          // Arbitrary value
  parameter [127:0] FACTORY_DATA = 128'h0, // Byte 0 in bits 127:120
  parameter [23:0] WRSR_CYC = 24'd1000,
  parameter [23:0] PP_CYC = 24'd2000,
  parameter [23:0] SE_CYC = 24'd4000,
  parameter [23:0] BE_CYC = 24'd8000
) (
  input wire clk_i,                 // 125 MHz clock
  input wire rst_i,                 // Synchronous reset, active high
  input wire ce_i,                  // Clock enable, freezes all state when low
  input wire sck_i,                 // Serial clock from host
  input wire cs_n_i,                // Chip select, active low
  input wire serial_in_i,           // Serial data in
  input wire write_protect_n_i,     // Write protect pin, active low
  output reg serial_out_o,          // Serial data out
  output reg serial_out_oe_o,       // Drive enable for serial_out_o
  output reg [7:0] status_o,        // Status byte
  output reg hardware_locked_mode_o // Locked mode indicator
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_CMD = 5'h02;
  localparam [4:0] ST_IN = 5'h04;
  localparam [4:0] ST_OUT = 5'h08;
  localparam [4:0] ST_SKIP = 5'h10;

  localparam [3:0] SYNC_PRESET = `FLSIP_SYNC_RESET;

  // Two-stage synchronisers, one per pin; stage 1 is read only by stage 2
  wire [3:0] pin_raw = {write_protect_n_i, serial_in_i, cs_n_i, sck_i};
  wire [3:0] pin_sync;
  reg sck_d_ff;
  reg cs_n_d_ff;
  wire sck_s = pin_sync[0];
  wire cs_n_s = pin_sync[1];
  wire din_s = pin_sync[2];
  wire wp_n_s = pin_sync[3];
  // Edges count only inside a frame, so clock activity while deselected is ignored
  wire sck_rise = sck_s & ~sck_d_ff & ~cs_n_s;
  wire sck_fall = ~sck_s & sck_d_ff & ~cs_n_s;
  wire cs_rise = cs_n_s & ~cs_n_d_ff;

  reg [4:0] state_ff;
  reg [4:0] nxt_state;
  reg [7:0] cmd_ff;
  reg [7:0] sh_in_ff;
  reg [2:0] bit_cnt_ff;
  reg [4:0] byte_cnt_ff;
  reg [23:0] addr_ff;
  reg [7:0] out_sh_ff;
  reg [2:0] obit_ff;
  reg [4:0] oidx_ff;
  reg latch_ff;
  reg busy_ff;
  reg [23:0] busy_cnt_ff;
  reg [7:0] busy_op_ff;
  reg [7:0] wrsr_val_ff;
  reg [2:0] guard_ff;
  reg lock_ff;

  wire [7:0] opcode = {sh_in_ff[6:0], din_s};
  wire locked = lock_ff & ~wp_n_s;
  wire [7:0] status_now = {lock_ff, 2'b00, guard_ff, latch_ff, busy_ff};

  // Identification byte by index; past the end the line reads zero
  function [7:0] id_byte;
    input [4:0] idx;
    begin
      case (idx)
        5'd0: id_byte = MAKER_ID;
        5'd1: id_byte = TYPE_ID;
        5'd2: id_byte = CAP_ID;
        5'd3: id_byte = `FLSIP_ID_LEN;
        default: id_byte = (idx < `FLSIP_ID_BYTES) ? FACTORY_DATA[8'd127 - {idx - 5'd4, 3'b000} -: 8] : 8'h00;
      endcase
    end
  endfunction

  // Guarded region grows downward from the top sector as the guard code rises
  function guarded;
    input [2:0] g;
    input [4:0] sect;
    reg [5:0] span;
    begin
      // Codes six and seven both cover the whole array; the shift alone would wrap at seven
      span = (g == 3'd0) ? 6'd0 : (g >= 3'd6) ? 6'd32 : (6'd1 << (g - 3'd1));
      guarded = ({1'b0, sect} >= (6'd32 - span));
    end
  endfunction

  // Whole byte taken from the table first, since a call result cannot be bit-selected
  wire [7:0] id_now = id_byte(oidx_ff);

  // Decode of the first byte; everything but status read is skipped during a busy cycle
  always @* begin
    nxt_state = ST_SKIP;
    if (opcode == `FLSIP_OP_RDSR) begin
      nxt_state = ST_OUT;
    end else if (busy_ff) begin
      nxt_state = ST_SKIP;
    end else if (opcode == `FLSIP_OP_RDID) begin
      nxt_state = ST_OUT;
    end else if (opcode == `FLSIP_OP_WREN || opcode == `FLSIP_OP_WRDI || opcode == `FLSIP_OP_WRSR ||
                 opcode == `FLSIP_OP_PP || opcode == `FLSIP_OP_SE || opcode == `FLSIP_OP_BE) begin
      nxt_state = ST_IN;
    end
  end

  wire aligned = (bit_cnt_ff == 3'd0);
  wire do_wrsr = (cmd_ff == `FLSIP_OP_WRSR) && byte_cnt_ff == `FLSIP_WRSR_BYTES && latch_ff && !locked;
  wire do_pp = (cmd_ff == `FLSIP_OP_PP) && byte_cnt_ff > `FLSIP_ADDR_BYTES && latch_ff &&
               !guarded(guard_ff, addr_ff[`FLSIP_SECT_HI:`FLSIP_SECT_LO]);
  wire do_se = (cmd_ff == `FLSIP_OP_SE) && byte_cnt_ff == `FLSIP_ADDR_BYTES && latch_ff &&
               !guarded(guard_ff, addr_ff[`FLSIP_SECT_HI:`FLSIP_SECT_LO]);
  wire do_be = (cmd_ff == `FLSIP_OP_BE) && byte_cnt_ff == 5'd0 && latch_ff && guard_ff == 3'd0;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      reg stage1_ff;
      reg stage2_ff;
      always @(posedge clk_i) begin
        if (rst_i) begin
          stage1_ff <= SYNC_PRESET[gi];
          stage2_ff <= SYNC_PRESET[gi];
        end else if (ce_i) begin
          stage1_ff <= pin_raw[gi];
          stage2_ff <= stage1_ff;
        end
      end
      assign pin_sync[gi] = stage2_ff;
    end
  endgenerate

  // Presets match the idle pins, so no edge is seen as reset lifts
  always @(posedge clk_i) begin
    if (rst_i) begin
      sck_d_ff <= 1'b0;
      cs_n_d_ff <= 1'b1;
    end else if (ce_i) begin
      sck_d_ff <= sck_s;
      cs_n_d_ff <= cs_n_s;
    end
  end

  // Frame sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      cmd_ff <= 8'h00;
      sh_in_ff <= 8'h00;
      bit_cnt_ff <= 3'd0;
      byte_cnt_ff <= 5'd0;
      addr_ff <= 24'h000000;
      out_sh_ff <= 8'h00;
      obit_ff <= 3'd0;
      oidx_ff <= 5'd0;
      serial_out_o <= 1'b0;
      serial_out_oe_o <= 1'b0;
    end else if (ce_i) begin
      if (cs_n_s) begin
        state_ff <= ST_IDLE;
        bit_cnt_ff <= 3'd0;
        byte_cnt_ff <= 5'd0;
        obit_ff <= 3'd0;
        oidx_ff <= 5'd0;
        serial_out_oe_o <= 1'b0;
      end else begin
        if (sck_rise) begin
          sh_in_ff <= {sh_in_ff[6:0], din_s};
          bit_cnt_ff <= bit_cnt_ff + 3'd1;
          if (bit_cnt_ff == 3'd7) begin
            case (state_ff)
              ST_IDLE, ST_CMD: begin
                cmd_ff <= opcode;
                state_ff <= nxt_state;
              end
              ST_IN: begin
                if (byte_cnt_ff < `FLSIP_ADDR_BYTES) begin
                  addr_ff <= {addr_ff[15:0], opcode};
                end
                if (byte_cnt_ff != 5'h1f) begin
                  byte_cnt_ff <= byte_cnt_ff + 5'd1;
                end
              end
              default: state_ff <= state_ff;
            endcase
          end else if (state_ff == ST_IDLE) begin
            state_ff <= ST_CMD;
          end
        end
        if (sck_fall && state_ff == ST_OUT) begin
          serial_out_oe_o <= 1'b1;
          obit_ff <= obit_ff + 3'd1;
          if (obit_ff == 3'd0) begin
            // Status is resampled for every repeated byte so busy can be polled
            if (cmd_ff == `FLSIP_OP_RDSR) begin
              serial_out_o <= status_now[7];
              out_sh_ff <= {status_now[6:0], 1'b0};
            end else begin
              serial_out_o <= id_now[7];
              out_sh_ff <= {id_now[6:0], 1'b0};
              if (oidx_ff != 5'h1f) begin
                oidx_ff <= oidx_ff + 5'd1;
              end
            end
          end else begin
            serial_out_o <= out_sh_ff[7];
            out_sh_ff <= {out_sh_ff[6:0], 1'b0};
          end
        end
      end
    end
  end

  // Write latch, internal cycles and nonvolatile bits
  always @(posedge clk_i) begin
    if (rst_i) begin
      latch_ff <= 1'b0;
      busy_ff <= 1'b0;
      busy_cnt_ff <= 24'd0;
      busy_op_ff <= 8'h00;
      wrsr_val_ff <= 8'h00;
      guard_ff <= `FLSIP_GUARD_RESET;
      lock_ff <= 1'b0;
      status_o <= `FLSIP_SR_RESET;
      hardware_locked_mode_o <= 1'b0;
    end else if (ce_i) begin
      status_o <= status_now;
      hardware_locked_mode_o <= locked;
      // Cycle length counts down from the load value and ends as the count reaches one
      if (busy_ff) begin
        busy_cnt_ff <= busy_cnt_ff - 24'd1;
        if (busy_cnt_ff == 24'd1) begin
          busy_ff <= 1'b0;
          latch_ff <= 1'b0;
          if (busy_op_ff == `FLSIP_OP_WRSR) begin
            guard_ff <= wrsr_val_ff[`FLSIP_SR_GUARD_HI:`FLSIP_SR_GUARD_LO];
            lock_ff <= wrsr_val_ff[`FLSIP_SR_LOCK];
          end
        end
      end else if (cs_rise && state_ff == ST_IN && aligned) begin
        // A refused write keeps the latch, so the host may retry without a new enable
        busy_op_ff <= cmd_ff;
        wrsr_val_ff <= addr_ff[7:0];
        case (cmd_ff)
          `FLSIP_OP_WREN: latch_ff <= 1'b1;
          `FLSIP_OP_WRDI: latch_ff <= 1'b0;
          `FLSIP_OP_WRSR: begin
            busy_ff <= do_wrsr;
            busy_cnt_ff <= WRSR_CYC;
          end
          `FLSIP_OP_PP: begin
            busy_ff <= do_pp;
            busy_cnt_ff <= PP_CYC;
          end
          `FLSIP_OP_SE: begin
            busy_ff <= do_se;
            busy_cnt_ff <= SE_CYC;
          end
          `FLSIP_OP_BE: begin
            busy_ff <= do_be;
            busy_cnt_ff <= BE_CYC;
          end
          default: busy_ff <= 1'b0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// [verif/flsip_properties.sv]
// Concurrent checks on the flash command block ports
`timescale 1ns/1ps
`default_nettype none
module flsip_props #(
  parameter [23:0] WRSR_CYC = 24'd1000,
  parameter [23:0] BE_CYC = 24'd8000
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Sync reset
  input wire logic ce_i, // Clock enable
  input wire logic sck_i, // Serial clock
  input wire logic cs_n_i, // Chip select
  input wire logic write_protect_n_i, // Protect pin
  input wire logic serial_out_o, // Serial out
  input wire logic serial_out_oe_o, // Out enable
  input wire logic [7:0] status_o, // Status byte
  input wire logic hardware_locked_mode_o // Locked mode
);
  logic [23:0] busy_ff;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Counts status cycles with busy shown, to bound the cycle length
  always @(posedge clk_i) begin
    if (rst_i || !status_o[0])
      busy_ff <= 24'h0;
    else if (ce_i)
      busy_ff <= busy_ff + 24'h1;
  end
  sequence s_cs_idle;
    cs_n_i [*6];
  endsequence
  sequence s_sck_high;
    sck_i [*6];
  endsequence
  a_bits_zero: assert property (status_o[6:5] == 2'b00) else $error("status bits 6:5 set");
  a_lock_on: assert property ((status_o[7] && !write_protect_n_i) [*8] |-> hardware_locked_mode_o)
    else $error("locked mode missing");
  a_lock_off: assert property (write_protect_n_i [*8] |-> !hardware_locked_mode_o)
    else $error("locked mode with pin high");
  a_locked_ro: assert property (hardware_locked_mode_o && $past(hardware_locked_mode_o) |-> $stable(status_o[7:2]))
    else $error("guard bits changed while locked");
  a_busy_latch: assert property ($rose(status_o[0]) |-> status_o[1] && $past(status_o[1]))
    else $error("cycle started without latch");
  a_end_clears: assert property ($fell(status_o[0]) |-> !status_o[1]) else $error("latch kept after cycle");
  a_guard_hold: assert property (!$stable(status_o[7:2]) |-> $fell(status_o[0]))
    else $error("guard bits changed outside a status write");
  a_busy_len: assert property ($fell(status_o[0]) |-> busy_ff + 24'h2 >= WRSR_CYC && busy_ff <= BE_CYC + 24'h2)
    else $error("busy length wrong");
  a_oe_release: assert property (s_cs_idle |-> !serial_out_oe_o) else $error("output driven while deselected");
  a_out_hold: assert property (s_sck_high |-> $stable(serial_out_o)) else $error("output moved with clock high");
endmodule
bind flsip_core flsip_props #(.WRSR_CYC(WRSR_CYC), .BE_CYC(BE_CYC)) u_props (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i),
  .sck_i(sck_i), .cs_n_i(cs_n_i), .write_protect_n_i(write_protect_n_i), .serial_out_o(serial_out_o),
  .serial_out_oe_o(serial_out_oe_o), .status_o(status_o), .hardware_locked_mode_o(hardware_locked_mode_o));
`default_nettype wire

// [verif/flsip_host.sv]
// Serial host model that frames commands and collects output bytes
`timescale 1ns/1ps
`default_nettype none
module flsip_host (
  input wire logic clk_i, // Bench clock
  input wire logic so_i, // Device output
  input wire logic oe_i, // Device drive enable
  output logic sck_o = 1'b0, // Serial clock, idles low
  output logic cs_n_o = 1'b1, // Chip select
  output logic si_o = 1'b0, // Serial data to device
  output logic [7:0] rx_o = 8'h00, // Last byte read
  output logic rx_vld_o = 1'b0 // Pulse per byte read
);
  // Sends the top nb bits of d, then clocks nrx bytes; idle input toggles so stale bits never pass
  task automatic frame(input logic [39:0] d, input int nb, input int nrx);
    logic b;
    b = 1'b0;
    @(posedge clk_i);
    #1 cs_n_o = 1'b0;
    for (int i = 0; i < nb + 8 * nrx; i++) begin
      si_o = (i < nb) ? d[39 - i] : ~si_o;
      #80 sck_o = 1'b1;
      b = oe_i ? so_i : ~b;
      if (i >= nb)
        rx_o = {rx_o[6:0], b};
      #80 sck_o = 1'b0;
      if (i >= nb && (i - nb) % 8 == 7) begin
        rx_vld_o = 1'b1;
        #1 rx_vld_o = 1'b0;
      end
    end
    #80 cs_n_o = 1'b1;
    si_o = ~si_o;
    #80;
  endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the flash command block
`timescale 1ns/1ps
`default_nettype none
`include "flsip_defs.vh"
module tb_top;
  localparam logic [23:0] CYC = 24'd2000;
  localparam logic [7:0] MK = 8'ha6; // Arbitrary identity value
  localparam logic [7:0] TY = 8'h71; // Arbitrary identity value
  localparam logic [7:0] CP = 8'h2b; // Arbitrary identity value
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic wp_n = 1'b1;
  wire sck, cs_n, si, so, oe, hml, rx_vld;
  wire [7:0] st, rx;
  int err_total = 0;
  int n_checks = 0;
  int oe_cnt = 0;
  int k;
  logic [7:0] exp_q[$];
  logic [7:0] d;
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) oe_cnt <= oe_cnt + int'(oe);
  flsip_core #(.MAKER_ID(MK), .TYPE_ID(TY), .CAP_ID(CP), .WRSR_CYC(CYC), .PP_CYC(CYC), .SE_CYC(CYC),
    .BE_CYC(CYC)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .sck_i(sck), .cs_n_i(cs_n), .serial_in_i(si), .write_protect_n_i(wp_n), .serial_out_o(so),
    .serial_out_oe_o(oe), .status_o(st), .hardware_locked_mode_o(hml));
  flsip_host i_host (.clk_i(clk_i), .so_i(so), .oe_i(oe), .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .rx_o(rx),
    .rx_vld_o(rx_vld));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  always @(posedge rx_vld) chk("rx", exp_q.pop_front(), rx);
  task automatic summarize;
    chk("left", 8'h00, 8'(exp_q.size()));
    if (err_total == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Two bytes show that the status byte repeats
  task automatic rdsr(input logic [7:0] e);
    exp_q.push_back(e);
    exp_q.push_back(e);
    i_host.frame({`FLSIP_OP_RDSR, 32'h0}, 8, 2);
  endtask
  task automatic cmd(input logic [39:0] v, input int nb);
    i_host.frame(v, nb, 0);
    repeat (8) @(posedge clk_i);
    #1;
  endtask
  task automatic wait_idle;
    for (int i = 0; st[0] !== 1'b0; i++) begin
      if (i > 3 * CYC) begin
        err_total++;
        summarize;
      end
      @(posedge clk_i);
      #1;
    end
  endtask
  task automatic wrsr(input logic [7:0] v);
    cmd({`FLSIP_OP_WREN, 32'h0}, 8);
    cmd({`FLSIP_OP_WRSR, v, 24'h0}, 16);
    wait_idle;
  endtask
  task automatic pin(input logic v);
    @(posedge clk_i);
    #1 wp_n = v;
    repeat (8) @(posedge clk_i);
    #1;
  endtask
  initial begin
    void'($urandom(32'hf8d5));
    repeat (2) @(posedge clk_i);
    #1 rst_i = 1'b0;
    repeat (4) @(posedge clk_i);
    chk("st_rst", 8'h00, st);
    rdsr(8'h00);
    for (int i = 0; i < 20; i++)
      exp_q.push_back(i == 0 ? MK : i == 1 ? TY : i == 2 ? CP : i == 3 ? `FLSIP_ID_LEN : 8'h00);
    i_host.frame({`FLSIP_OP_RDID, 32'h0}, 8, 20);
    exp_q.push_back(MK);
    i_host.frame({`FLSIP_OP_RDID, 32'h0}, 8, 1);
    rdsr(8'h00);
    d = 8'($urandom);
    cmd({`FLSIP_OP_WRSR, d, 24'h0}, 16);
    chk("wrsr_nolatch", 8'h00, st);
    cmd({`FLSIP_OP_WREN, 32'h0}, 8);
    cmd({`FLSIP_OP_WRDI, 32'h0}, 9);
    chk("wrdi_short", 8'h02, st);
    cmd({`FLSIP_OP_WRDI, 32'h0}, 8);
    chk("wrdi", 8'h00, st);
    cmd({`FLSIP_OP_WREN, 32'h0}, 8);
    cmd({`FLSIP_OP_WRSR, d, 24'h0}, 16);
    rdsr(8'h03);
    k = oe_cnt;
    i_host.frame({`FLSIP_OP_RDID, 32'h0}, 8, 0);
    chk("rdid_busy", 8'h00, 8'(oe_cnt - k));
    wait_idle;
    repeat (2) @(posedge clk_i);
    chk("wrsr", {d[7], 2'b00, d[4:2], 2'b00}, st);
    wrsr(8'h84);
    pin(1'b0);
    chk("hml", 8'h01, {7'h0, hml});
    wrsr(8'h00);
    chk("locked", 8'h86, st);
    cmd({`FLSIP_OP_SE, 24'h1f0000, 8'h0}, 32);
    chk("se_guard", 8'h86, st);
    cmd({`FLSIP_OP_BE, 32'h0}, 8);
    chk("be_guard", 8'h86, st);
    cmd({`FLSIP_OP_PP, 24'h1f0000, 8'ha5}, 40);
    chk("pp_guard", 8'h86, st);
    cmd({`FLSIP_OP_PP, 24'h000000, 8'ha5}, 40);
    chk("pp_run", 8'h87, st);
    wait_idle;
    chk("pp_done", 8'h84, st);
    pin(1'b1);
    chk("hml_off", 8'h00, {7'h0, hml});
    wrsr(8'h00);
    chk("unlock", 8'h00, st);
    cmd({`FLSIP_OP_WREN, 32'h0}, 8);
    cmd({`FLSIP_OP_BE, 32'h0}, 8);
    chk("be_run", 8'h03, st);
    ce_i = 1'b0;
    repeat (CYC + 100) @(posedge clk_i);
    chk("ce_hold", 8'h03, st);
    #1 ce_i = 1'b1;
    wait_idle;
    chk("be_done", 8'h00, st);
    summarize;
  end
endmodule
`default_nettype wire
